// ===== kbr_pkg.sv
// Constants, register map and types of the keypad interrupt and brownout reset control block.
package kbr_pkg;

	// Register byte addresses on the plain register port.
	localparam logic [7:0] ADDR_KEY_EN   = 8'ha1;
	localparam logic [7:0] ADDR_AUX      = 8'ha2;
	localparam logic [7:0] ADDR_UNLOCK   = 8'hc7;
	localparam logic [7:0] ADDR_KEY_LVL  = 8'hd0;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'hd1;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hd2;

	// Field positions of the system aux control register.
	localparam int AUX_KEY_FLAG  = 7;
	localparam int AUX_BOD       = 6;
	localparam int AUX_BOI       = 5;
	localparam int AUX_LPS       = 4;
	localparam int AUX_SOFT_CHIP_RESET      = 3;
	localparam int AUX_LVL_HI    = 2;
	localparam int AUX_LVL_LO    = 1;
	localparam int AUX_STATE     = 0;

	// Interrupt status and mask bit positions.
	localparam int IRQ_KEY       = 0;
	localparam int IRQ_BROWN     = 1;

	// Reset values.
	localparam logic [7:0] KEY_EN_RST  = 8'h00;
	localparam logic [7:0] KEY_LVL_RST = 8'h00;
	localparam logic [1:0] IRQ_RST     = 2'h0;
	localparam logic [1:0] LVL_RST     = 2'h0;

	// Timed access unlock keys and open window.
	localparam logic [7:0] UNLOCK_KEY1   = 8'haa;
	localparam logic [7:0] UNLOCK_KEY2   = 8'h55;
	localparam logic [2:0] UNLOCK_WINDOW = 3'h4;

	// Chip reset request length in cycles.
	localparam logic [4:0] CHIP_RST_CYCLES = 5'h10;

	// Low-power sampling: one phase lasts SAMPLE_NS, sixteen phases per period.
	localparam int         CLK_PERIOD_NS = 10;
	localparam int         SAMPLE_NS     = 1000;
	localparam logic [7:0] SAMPLE_DIV    = 8'((SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] SAMPLE_ON_PH  = 4'h0;

	// Threshold codes driven to the analogue comparator.
	localparam logic [1:0] THR_2V6 = 2'h0;
	localparam logic [1:0] THR_3V8 = 2'h1;
	localparam logic [1:0] THR_4V5 = 2'h2;

	// Timed access unlock sequence states.
	typedef enum logic [1:0] {
		UNL_IDLE,
		UNL_ARMED,
		UNL_OPEN
	} kbr_unlock_t;

	// Maps the brownout level field to the comparator threshold code.
	function automatic logic [1:0] kbr_thr_code(input logic [1:0] lvl);
		logic [1:0] code;
		code = THR_2V6;
		if (lvl == 2'h2) begin
			code = THR_3V8;
		end else if (lvl == 2'h3) begin
			code = THR_4V5;
		end
		return code;
	endfunction

	// Filter step: a bit follows once the second and third synchroniser stages agree.
	function automatic logic [7:0] kbr_agree(input logic [7:0] s2, input logic [7:0] s3,
		input logic [7:0] held);
		return (~(s2 ^ s3) & s2) | ((s2 ^ s3) & held);
	endfunction

endpackage

// ===== kbr_ctrl.sv
// Keypad interrupt, brownout control and protected soft chip reset.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
module kbr_ctrl
	import kbr_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst,
	// Register port.
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdata,
	// Pins and analogue comparator.
	input  wire logic [7:0] keypadPin,
	input  wire logic       brownoutBelow,
	// CPU state and configuration bits.
	input  wire logic       cpuPowerDown,
	input  wire logic       cfgBrownoutOffN,
	input  wire logic [1:0] cfgBrownoutLevelN,
	// Outputs to the chip.
	output logic            irq,
	output logic            chipResetReq,
	output logic            brownoutDetEnable,
	output logic            rcOscEnable,
	output logic      [1:0] brownoutThrSel
);

	// Registers.
	logic [7:0]  keyEn_q;
	logic [7:0]  keyLvl_q;
	logic        keyFlag_q;
	logic        bod_q;
	logic        boi_q;
	logic        lps_q;
	logic [1:0]  lvl_q;
	logic [1:0]  irqStat_q;
	logic [1:0]  irqMask_q;
	logic        cfgLoad_q;
	logic [7:0]  keySync1_q;
	logic [7:0]  keySync2_q;
	logic [7:0]  keySync3_q;
	logic [7:0]  keyPin_q;
	logic        brSync1_q;
	logic        brSync2_q;
	logic        brSync3_q;
	logic        brFilt_q;
	logic        brSeen_q;
	logic [7:0]  divCnt_q;
	logic [3:0]  phase_q;
	logic [4:0]  rstCnt_q;
	logic [2:0]  unlockCnt_q;
	kbr_unlock_t unlock_q;
	kbr_unlock_t unlock_d;
	logic [2:0]  unlockCnt_d;

	// Address decode and strobes.
	wire selKeyEn  = regAddr == ADDR_KEY_EN;
	wire selAux    = regAddr == ADDR_AUX;
	wire selUnlock = regAddr == ADDR_UNLOCK;
	wire selKeyLvl = regAddr == ADDR_KEY_LVL;
	wire selStat   = regAddr == ADDR_IRQ_STAT;
	wire selMask   = regAddr == ADDR_IRQ_MASK;
	wire wrAux     = regWr & selAux;
	wire wrUnlock  = regWr & selUnlock;
	wire wrStat    = regWr & selStat;

	// Keypad trigger: an enabled pin whose filtered level equals its trigger level.
	wire [7:0] keyMatch = keyEn_q & ~(keyPin_q ^ keyLvl_q);
	wire       keyHit   = |keyMatch;
	// Software clears the flag by writing 0 to bit 7; a hit in the same cycle wins.
	wire       keyClr   = wrAux & ~regWdata[AUX_KEY_FLAG];
	wire       keyFlag_d = keyHit | (keyFlag_q & ~keyClr);

	// Brownout detector power: on always, or one phase in sixteen in power-down with LPS set.
	wire phaseOn  = phase_q == SAMPLE_ON_PH;
	wire detOn    = ~bod_q & (~lps_q | ~cpuPowerDown | phaseOn);
	wire rcOn     = ~bod_q & lps_q & cpuPowerDown;
	wire divTick  = divCnt_q == SAMPLE_DIV - 8'h01;

	// A new brownout is a rising filtered comparator seen while powered.
	wire brRise   = brownoutDetEnable & brFilt_q & ~brSeen_q;
	wire brIrqEv  = brRise & boi_q;
	wire brRstEv  = brRise & ~boi_q;

	// Soft chip reset is only taken inside an open unlock window.
	wire srstTry    = wrAux & regWdata[AUX_SOFT_CHIP_RESET];
	wire srstAccept = srstTry & (unlock_q == UNL_OPEN);

	// Interrupt status: events set, write one clears, set wins.
	wire [1:0] irqEv     = {brIrqEv, keyHit};
	wire [1:0] irqClr    = wrStat ? regWdata[1:0] : 2'h0;
	wire [1:0] irqStat_d = irqEv | (irqStat_q & ~irqClr);

	// Read multiplexer; unmapped addresses read zero.
	wire [7:0] auxRead = {keyFlag_q, bod_q, boi_q, lps_q, 1'b0, lvl_q, brSeen_q};
	wire [7:0] rdMux   = selKeyEn  ? keyEn_q :
	                     selAux    ? auxRead :
	                     selUnlock ? {7'h00, unlock_q == UNL_OPEN} :
	                     selKeyLvl ? keyLvl_q :
	                     selStat   ? {6'h00, irqStat_q} :
	                     selMask   ? {6'h00, irqMask_q} : 8'h00;

	// Unlock sequence: key one, then key two, then a short window for one write.
	always_comb begin
		unlock_d    = unlock_q;
		unlockCnt_d = unlockCnt_q;
		case (unlock_q)
			UNL_IDLE: begin
				if (wrUnlock && regWdata == UNLOCK_KEY1) begin
					unlock_d = UNL_ARMED;
				end
			end
			UNL_ARMED: begin
				if (wrUnlock) begin
					if (regWdata == UNLOCK_KEY2) begin
						unlock_d    = UNL_OPEN;
						unlockCnt_d = UNLOCK_WINDOW;
					end else begin
						unlock_d = UNL_IDLE;
					end
				end
			end
			UNL_OPEN: begin
				unlockCnt_d = 3'(unlockCnt_q - 3'h1);
				if (wrAux || wrUnlock || unlockCnt_q == 3'h1) begin
					unlock_d = UNL_IDLE;
				end
			end
			default: begin
				unlock_d = UNL_IDLE;
			end
		endcase
	end

	// Synchronisers: three stages, the filter looks only at the second and third.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			keySync1_q <= 8'h00;
			keySync2_q <= 8'h00;
			keySync3_q <= 8'h00;
			keyPin_q   <= 8'hff;
			brSync1_q  <= 1'b0;
			brSync2_q  <= 1'b0;
			brSync3_q  <= 1'b0;
			brFilt_q   <= 1'b0;
		end else begin
			keySync1_q <= keypadPin;
			keySync2_q <= keySync1_q;
			keySync3_q <= keySync2_q;
			keyPin_q   <= kbr_agree(keySync2_q, keySync3_q, keyPin_q);
			brSync1_q  <= brownoutBelow;
			brSync2_q  <= brSync1_q;
			brSync3_q  <= brSync2_q;
			brFilt_q   <= (brSync2_q == brSync3_q) ? brSync2_q : brFilt_q;
		end
	end

	// Plain software registers.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			keyEn_q   <= KEY_EN_RST;
			keyLvl_q  <= KEY_LVL_RST;
			irqMask_q <= IRQ_RST;
			boi_q     <= 1'b0;
			lps_q     <= 1'b0;
		end else begin
			if (regWr && selKeyEn) begin
				keyEn_q <= regWdata;
			end
			if (regWr && selKeyLvl) begin
				keyLvl_q <= regWdata;
			end
			if (regWr && selMask) begin
				irqMask_q <= regWdata[1:0];
			end
			if (wrAux) begin
				boi_q <= regWdata[AUX_BOI];
				lps_q <= regWdata[AUX_LPS];
			end
		end
	end

	// Configuration-loaded fields; the straps are taken one edge after reset release,
	// since an asynchronous reset may only load constants.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfgLoad_q <= 1'b1;
			bod_q     <= 1'b1;
			lvl_q     <= LVL_RST;
		end else begin
			cfgLoad_q <= 1'b0;
			if (cfgLoad_q) begin
				bod_q <= ~cfgBrownoutOffN;
				lvl_q <= ~cfgBrownoutLevelN;
			end else if (wrAux) begin
				bod_q <= regWdata[AUX_BOD];
				lvl_q <= regWdata[AUX_LVL_HI:AUX_LVL_LO];
			end
		end
	end

	// Flags, sampling divider, unlock state and brownout tracking.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			keyFlag_q   <= 1'b0;
			irqStat_q   <= IRQ_RST;
			divCnt_q    <= 8'h00;
			phase_q     <= 4'h0;
			unlock_q    <= UNL_IDLE;
			unlockCnt_q <= 3'h0;
			brSeen_q    <= 1'b0;
		end else begin
			keyFlag_q   <= keyFlag_d;
			irqStat_q   <= irqStat_d;
			divCnt_q    <= divTick ? 8'h00 : 8'(divCnt_q + 8'h01);
			phase_q     <= divTick ? 4'(phase_q + 4'h1) : phase_q;
			unlock_q    <= unlock_d;
			unlockCnt_q <= unlockCnt_d;
			// The state bit holds its last sample while the detector is unpowered.
			brSeen_q    <= brownoutDetEnable ? brFilt_q : brSeen_q;
		end
	end

	// Outputs, each from its own flip-flop. The chip reset request is stretched so
	// that the reset tree sees it for a fixed time whatever caused it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regRdata          <= 8'h00;
			irq               <= 1'b0;
			rstCnt_q          <= 5'h00;
			chipResetReq      <= 1'b0;
			brownoutDetEnable <= 1'b0;
			rcOscEnable       <= 1'b0;
			brownoutThrSel    <= THR_2V6;
		end else begin
			regRdata          <= regRd ? rdMux : 8'h00;
			irq               <= |(irqStat_d & irqMask_q);
			if (srstAccept || brRstEv) begin
				rstCnt_q     <= CHIP_RST_CYCLES;
				chipResetReq <= 1'b1;
			end else if (rstCnt_q != 5'h00) begin
				rstCnt_q     <= 5'(rstCnt_q - 5'h01);
				chipResetReq <= rstCnt_q != 5'h01;
			end
			brownoutDetEnable <= detOn;
			rcOscEnable       <= rcOn;
			brownoutThrSel    <= kbr_thr_code(lvl_q);
		end
	end

	// Checks next to the logic they guard.
	a_key_source: assert property (@(posedge clk) disable iff (rst)
		(keyEn_q == 8'h00 && !keyFlag_q && !keyClr) |=> !keyFlag_q)
		else $error("keypad flag set with no source enabled");

	a_key_flag_set: assert property (@(posedge clk) disable iff (rst)
		keyHit |=> keyFlag_q && irqStat_q[IRQ_KEY])
		else $error("keypad hit did not set the flag");

	a_key_flag_hold: assert property (@(posedge clk) disable iff (rst)
		(keyFlag_q && !keyClr) |=> keyFlag_q)
		else $error("keypad flag cleared without software");

	a_bod_off: assert property (@(posedge clk) disable iff (rst)
		bod_q |=> !brownoutDetEnable && !rcOscEnable)
		else $error("detector powered while disabled");

	a_cfg_load: assert property (@(posedge clk) disable iff (rst)
		$fell(cfgLoad_q) |-> (bod_q == !$past(cfgBrownoutOffN)))
		else $error("brownout disable not loaded from configuration");

	a_lvl_load: assert property (@(posedge clk) disable iff (rst)
		$fell(cfgLoad_q) |-> (lvl_q == ~$past(cfgBrownoutLevelN)))
		else $error("brownout level not loaded from configuration");

	a_brown_irq: assert property (@(posedge clk) disable iff (rst)
		brIrqEv |=> irqStat_q[IRQ_BROWN] && !chipResetReq)
		else $error("brownout in interrupt mode misbehaved");

	a_always_on: assert property (@(posedge clk) disable iff (rst)
		(!bod_q && !lps_q) |=> brownoutDetEnable)
		else $error("detector not continuously on");

	a_lp_duty: assert property (@(posedge clk) disable iff (rst)
		(!bod_q && lps_q && cpuPowerDown) |=> rcOscEnable && (brownoutDetEnable == $past(phaseOn)))
		else $error("low-power sampling duty wrong");

	a_soft_chip_reset_pulse: assert property (@(posedge clk) disable iff (rst)
		srstAccept |=> chipResetReq [*8])
		else $error("soft chip reset request too short");

	a_soft_chip_reset_locked: assert property (@(posedge clk) disable iff (rst)
		(srstTry && unlock_q != UNL_OPEN && !brRstEv && rstCnt_q == 5'h00) |=> !chipResetReq)
		else $error("soft chip reset taken without unlock");

	a_thr_code: assert property (@(posedge clk) disable iff (rst)
		(lvl_q == 2'h3) ##1 (lvl_q == 2'h3) |-> (brownoutThrSel == THR_4V5))
		else $error("threshold code does not follow level field");

	a_state_bit: assert property (@(posedge clk) disable iff (rst)
		(brownoutDetEnable && brFilt_q) |=> auxRead[AUX_STATE])
		else $error("brownout state bit missed a low supply");

	a_brown_reset: assert property (@(posedge clk) disable iff (rst)
		brRstEv |=> chipResetReq ##1 chipResetReq)
		else $error("brownout did not reset the chip");

endmodule

// ===== kbr_pins.sv
// Far-side model of the port 0 pins and the analogue brownout comparator.
`timescale 1ns/1ns
module kbr_pins (
	// Clock and requested levels.
	input  wire logic       clk,
	input  wire logic [7:0] pinLevel,
	input  wire logic       supplyLow,
	input  wire logic       detPower,
	// Modelled pins and comparator.
	output logic      [7:0] keypadPin,
	output logic            brownoutBelow
);
	initial begin
		keypadPin = 8'h00;
		brownoutBelow = 1'b0;
	end

	// Pins move off the clock edge, as real pins do. An unpowered comparator gives no
	// trustworthy answer, so it toggles instead of holding its last level.
	always @(posedge clk) begin
		keypadPin <= #3 pinLevel;
		brownoutBelow <= #3 detPower ? supplyLow : ~brownoutBelow;
	end
endmodule

// ===== kbr_ctrl_bench.sv
// Self-checking bench for the keypad and brownout control block.
`timescale 1ns/1ns
module kbr_ctrl_bench
	import kbr_pkg::*;
;
	logic       clk, rst, regWr, regRd, cpuPowerDown, cfgOffN, supplyLow, irq;
	logic       brownoutBelow, chipResetReq, detEn, rcOsc;
	logic [7:0] regAddr, regWdata, regRdata, pinLevel, keypadPin, en, lv;
	logic [1:0] cfgLvlN, thrSel;
	int         num_errors, num_checks, cyc, auxM, n, k;

	// Design and the pin and comparator model.
	kbr_ctrl u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .keypadPin(keypadPin),
		.brownoutBelow(brownoutBelow), .cpuPowerDown(cpuPowerDown),
		.cfgBrownoutOffN(cfgOffN), .cfgBrownoutLevelN(cfgLvlN), .irq(irq),
		.chipResetReq(chipResetReq), .brownoutDetEnable(detEn), .rcOscEnable(rcOsc),
		.brownoutThrSel(thrSel));
	kbr_pins u_pins (.clk(clk), .pinLevel(pinLevel), .supplyLow(supplyLow),
		.detPower(detEn), .keypadPin(keypadPin), .brownoutBelow(brownoutBelow));

	// Clock and a hang guard well above the expected run of about 3700 cycles.
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			$display("BAD t=%0t timeout", $time);
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Bus cycles: strobes rise after an edge and drop after the edge that takes them.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		chk(regRdata, exp);
	endtask

	// The model keeps the flag only when bit 7 is written as 1; bit 3 always reads 0.
	task automatic wrAux(input logic [7:0] d);
		wr(ADDR_AUX, d);
		auxM = (auxM & (d[7] ? 8'h81 : 8'h01)) | (d & 8'h76);
	endtask

	// Leaves the strobe up so the next write follows the keys with no gap.
	task automatic unlock();
		@(posedge clk);
		regAddr <= ADDR_UNLOCK;
		regWdata <= UNLOCK_KEY1;
		regWr <= 1'b1;
		@(posedge clk);
		regWdata <= UNLOCK_KEY2;
	endtask

	task automatic settle(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	// Called in the step of the edge that takes a request, so the cycle after it counts too.
	task automatic countRst(output int c);
		c = 0;
		#1;
		c += chipResetReq;
		repeat (29) begin
			@(posedge clk);
			#1;
			c += chipResetReq;
		end
	endtask

	task automatic doReset(input logic offN, input logic [1:0] lvlN);
		@(posedge clk);
		cfgOffN <= offN;
		cfgLvlN <= lvlN;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		settle(2);
		auxM = {1'b0, ~offN, 3'h0, ~lvlN, 1'b0};
	endtask

	// Main sequence.
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		cpuPowerDown = 1'b0;
		supplyLow = 1'b0;
		pinLevel = 8'hff;
		cfgOffN = 1'b1;
		cfgLvlN = 2'b01;
		void'($urandom(22));
		doReset(1'b1, 2'b01);
		rdc(ADDR_AUX, auxM[7:0]);
		chk(thrSel, THR_3V8);
		chk(detEn, 1'b1);
		rdc(ADDR_KEY_EN, KEY_EN_RST);
		wr(8'h33, 8'hff);
		rdc(8'h33, 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			wrAux(8'(i << 1));
			settle(2);
			chk(thrSel, i < 2 ? THR_2V6 : (i == 2 ? THR_3V8 : THR_4V5));
			rdc(ADDR_AUX, auxM[7:0]);
		end
		$display("test threshold select done");
		en = 8'($urandom);
		lv = 8'($urandom);
		// Levels are set and the pins settled before any source is enabled, so the
		// moving synchroniser cannot raise a stray hit.
		@(posedge clk) pinLevel <= ~lv;
		wr(ADDR_KEY_LVL, lv);
		settle(8);
		wr(ADDR_KEY_EN, en);
		wr(ADDR_IRQ_MASK, 8'h01);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk) pinLevel <= ~lv ^ (8'h01 << i);
			settle(8);
			chk(irq, en[i]);
			@(posedge clk) pinLevel <= ~lv;
			settle(8);
			auxM = auxM | (en[i] << 7);
			rdc(ADDR_AUX, auxM[7:0]);
			rdc(ADDR_IRQ_STAT, {7'h00, en[i]});
			wrAux(auxM[7:0] & 8'h7f);
			wr(ADDR_IRQ_STAT, 8'h01);
			rdc(ADDR_AUX, auxM[7:0]);
		end
		$display("test keypad done");
		wr(ADDR_IRQ_MASK, 8'h02);
		wrAux(8'h20);
		@(posedge clk) supplyLow <= 1'b1;
		settle(10);
		chk(irq, 1'b1);
		chk(chipResetReq, 1'b0);
		rdc(ADDR_AUX, 8'h21);
		@(posedge clk) supplyLow <= 1'b0;
		settle(10);
		rdc(ADDR_AUX, 8'h20);
		wr(ADDR_IRQ_STAT, 8'h02);
		settle(2);
		chk(irq, 1'b0);
		wrAux(8'h00);
		@(posedge clk) supplyLow <= 1'b1;
		countRst(n);
		chk(16'(n), 16'(CHIP_RST_CYCLES));
		rdc(ADDR_IRQ_STAT, 8'h00);
		@(posedge clk) supplyLow <= 1'b0;
		settle(10);
		$display("test brownout modes done");
		wrAux(8'h60);
		@(posedge clk) supplyLow <= 1'b1;
		settle(10);
		chk(detEn, 1'b0);
		rdc(ADDR_IRQ_STAT, 8'h00);
		@(posedge clk) supplyLow <= 1'b0;
		wrAux(8'h20);
		settle(10);
		wr(ADDR_IRQ_STAT, 8'h03);
		$display("test detector off done");
		wrAux(8'h28);
		countRst(n);
		chk(16'(n), 16'h0000);
		unlock();
		wrAux(8'h28);
		countRst(n);
		chk(16'(n), 16'(CHIP_RST_CYCLES));
		rdc(ADDR_AUX, auxM[7:0]);
		$display("test soft reset done");
		@(posedge clk) cpuPowerDown <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			wrAux(8'(8'h20 | (m << 4)));
			settle(2);
			n = 0;
			k = 0;
			repeat (16 * SAMPLE_DIV) begin
				@(posedge clk);
				#1;
				n += detEn;
				k += rcOsc;
			end
			chk(16'(n), m ? 16'(SAMPLE_DIV) : 16'(16 * SAMPLE_DIV));
			if (m == 1) begin
				chk(16'(k), 16'(16 * SAMPLE_DIV));
			end
		end
		@(posedge clk) cpuPowerDown <= 1'b0;
		$display("test low power sampling done");
		doReset(1'b0, 2'b11);
		rdc(ADDR_AUX, auxM[7:0]);
		chk(detEn, 1'b0);
		chk(thrSel, THR_2V6);
		$display("test second reset done");
		wrap_up();
	end
endmodule
